//--- atpo_pkg.sv
// package for the test route, profile, trigger and offset calibration bank
package atpo_pkg;
    // register addresses
    localparam logic [8:0] ADDR_RSVD_ZERO_A   = 9'h106;
    localparam logic [8:0] ADDR_RSVD_RO       = 9'h107;
    localparam logic [8:0] ADDR_RSVD_ZERO_B   = 9'h108;
    localparam logic [8:0] ADDR_FILTER_TEST   = 9'h109;
    localparam logic [8:0] ADDR_PROFILE_TRIG  = 9'h10C;
    localparam logic [8:0] ADDR_RSVD_ONES_A   = 9'h10D;
    localparam logic [8:0] ADDR_RSVD_ONES_B   = 9'h10E;
    localparam logic [8:0] ADDR_OFFSET_CAL    = 9'h10F;
    // reset values
    localparam logic [7:0] RST_ZERO           = 8'h00;
    localparam logic [7:0] RST_ONES           = 8'hFF;
    // field positions
    localparam int TEST_EN_BIT                = 4;
    localparam int TEST_SEL_LSB               = 0;
    localparam int TRIG_BIT                   = 5;
    localparam int PROFILE_LSB                = 0;
    localparam int CAL_DONE_BIT               = 3;
    localparam int CAL_CNT_LSB                = 0;
    // averaging: 2^(CAL_LOG_BASE + code - 1) samples
    localparam logic [4:0] CAL_LOG_BASE       = 5'h0A;
    localparam logic [2:0] CAL_OFF            = 3'h0;

    // register read/write request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [8:0] addr;
        logic [7:0] wdata;
    } atpo_req_s;

    typedef enum logic [1:0] {
        ATPO_CAL_IDLE,
        ATPO_CAL_RUN,
        ATPO_CAL_DONE
    } atpo_cal_e;
endpackage

//--- atpo_ctrl.sv
// control register bank with test mux, trigger select and offset calibration
`timescale 1ns/10ps

// Operation
// [RULE1] test enable routes the selected channel filter to the gpo pins.
// [RULE2] with the manual bit clear the trigger follows the external pin.
// [RULE3] writing one to the manual bit fires one trigger and self-clears.
// [RULE4] cal code 000 disables and clears; 001..111 average 2^10..2^16.
// [RULE5] read-only cal status is zero until averaging finishes, then one.
// [RULE6] a 5-bit profile index picks the active entry and resets to zero.
module atpo_ctrl
(
    input  wire logic                clk_i,
    input  wire logic                resetn_i,
    input  wire atpo_pkg::atpo_req_s req_i,
    output logic [7:0]               rdata_o,
    input  wire logic [7:0]          filter_out_p_i,
    input  wire logic [7:0]          filter_out_n_i,
    output logic                     general_output_pin_two_o,
    output logic                     general_output_pin_three_o,
    output logic                     test_route_active_o,
    input  wire logic                ext_trigger_i,
    output logic                     transmit_trigger_o,
    output logic [4:0]               profile_index_o,
    input  wire logic                sample_valid_i,
    output logic                     correction_enable_o,
    output logic                     correction_clear_o
);
    import atpo_pkg::*;

    logic [7:0]  filter_test_route;
    logic [7:0]  next_filter_test_route;
    logic [4:0]  profile_index;
    logic [4:0]  next_profile_index;
    logic        manual_trig;
    logic        next_manual_trig;
    logic [2:0]  cal_count;
    logic [2:0]  next_cal_count;
    atpo_cal_e   cal_state;
    atpo_cal_e   next_cal_state;
    logic [16:0] cal_samples;
    logic [16:0] next_cal_samples;
    logic [16:0] cal_target;
    logic [7:0]  next_rdata;
    logic        next_general_output_pin_two;
    logic        next_general_output_pin_three;
    logic        next_trig;
    logic        next_corr_clear;
    logic        cal_wr;

    // sample count target for the current code
    assign cal_target = 17'h00001 << (CAL_LOG_BASE + 5'(cal_count) - 5'h01);
    assign cal_wr     = req_i.wr && (req_i.addr == ADDR_OFFSET_CAL);

    // register writes and self-clearing trigger bit
    always_comb
    begin
        next_filter_test_route = filter_test_route;
        next_profile_index     = profile_index;
        next_manual_trig       = 1'b0;                         // [RULE3]
        next_cal_count         = cal_count;
        if (req_i.wr && req_i.addr == ADDR_FILTER_TEST)
        begin
            next_filter_test_route = req_i.wdata & 8'h17;      // [RULE1]
        end
        if (req_i.wr && req_i.addr == ADDR_PROFILE_TRIG)
        begin
            next_profile_index = req_i.wdata[PROFILE_LSB +: 5]; // [RULE6]
            next_manual_trig   = req_i.wdata[TRIG_BIT];        // [RULE3]
        end
        if (cal_wr)
        begin
            next_cal_count = req_i.wdata[CAL_CNT_LSB +: 3];
        end
    end

    // calibration sequencer; a rewrite of the code restarts averaging
    always_comb
    begin
        next_cal_state   = cal_state;
        next_cal_samples = cal_samples;
        next_corr_clear  = 1'b0;
        case (cal_state)
            ATPO_CAL_IDLE:
            begin
                next_cal_samples = 17'h00000;
                if (cal_count != CAL_OFF)
                begin
                    next_cal_state = ATPO_CAL_RUN;             // [RULE4]
                end
            end
            ATPO_CAL_RUN:
            begin
                if (sample_valid_i)
                begin
                    next_cal_samples = cal_samples + 17'h00001;
                end
                if (sample_valid_i && cal_samples + 17'h00001 == cal_target)
                begin
                    next_cal_state = ATPO_CAL_DONE;            // [RULE5]
                end
            end
            ATPO_CAL_DONE:
            begin
                next_cal_state = ATPO_CAL_DONE;
            end
            default:
            begin
                next_cal_state = ATPO_CAL_IDLE;
            end
        endcase
        if (cal_wr)
        begin
            next_cal_state   = ATPO_CAL_IDLE;
            next_cal_samples = 17'h00000;
        end
        if (cal_wr && req_i.wdata[CAL_CNT_LSB +: 3] == CAL_OFF)
        begin
            next_corr_clear = 1'b1;                            // [RULE4]
        end
    end

    // outputs and read mux
    always_comb
    begin
        next_general_output_pin_two = 1'b0;
        next_general_output_pin_three = 1'b0;
        if (filter_test_route[TEST_EN_BIT])
        begin
            // [RULE1]
            next_general_output_pin_two = filter_out_p_i[filter_test_route[TEST_SEL_LSB +: 3]];
            next_general_output_pin_three = filter_out_n_i[filter_test_route[TEST_SEL_LSB +: 3]];
        end
        // [RULE2] [RULE3]
        next_trig = manual_trig ? 1'b1 : ext_trigger_i;
        next_rdata = RST_ZERO;
        case (req_i.addr)
            ADDR_FILTER_TEST:  next_rdata = filter_test_route;
            ADDR_PROFILE_TRIG: next_rdata = {2'b00, manual_trig, profile_index};
            ADDR_RSVD_ONES_A:  next_rdata = RST_ONES;
            ADDR_RSVD_ONES_B:  next_rdata = RST_ONES;
            // [RULE5]
            ADDR_OFFSET_CAL:   next_rdata = {4'h0,
                                             cal_state == ATPO_CAL_DONE,
                                             cal_count};
            default:           next_rdata = RST_ZERO;
        endcase
    end

    // state registers; all ports come from flops
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            filter_test_route          <= RST_ZERO;
            profile_index              <= 5'h00;               // [RULE6]
            manual_trig                <= 1'b0;                // [RULE2]
            cal_count                  <= CAL_OFF;
            cal_state                  <= ATPO_CAL_IDLE;       // [RULE5]
            cal_samples                <= 17'h00000;
            rdata_o                    <= RST_ZERO;
            general_output_pin_two_o   <= 1'b0;
            general_output_pin_three_o <= 1'b0;
            test_route_active_o        <= 1'b0;
            transmit_trigger_o         <= 1'b0;
            profile_index_o            <= 5'h00;
            correction_enable_o        <= 1'b0;
            correction_clear_o         <= 1'b0;
        end
        else
        begin
            filter_test_route          <= next_filter_test_route;
            profile_index              <= next_profile_index;
            manual_trig                <= next_manual_trig;
            cal_count                  <= next_cal_count;
            cal_state                  <= next_cal_state;
            cal_samples                <= next_cal_samples;
            rdata_o                    <= next_rdata;
            general_output_pin_two_o   <= next_general_output_pin_two;
            general_output_pin_three_o <= next_general_output_pin_three;
            test_route_active_o        <= filter_test_route[TEST_EN_BIT];
            transmit_trigger_o         <= next_trig;
            profile_index_o            <= profile_index;
            correction_enable_o        <= cal_count != CAL_OFF; // [RULE4]
            correction_clear_o         <= next_corr_clear;
        end
    end
endmodule

//--- atpo_ctrl_monitor.sv
// assertion checker for the control bank ports
`timescale 1ns/10ps
module atpo_ctrl_monitor
(
    input wire logic                clk_i,
    input wire logic                resetn_i,
    input wire atpo_pkg::atpo_req_s req_i,
    input wire logic [7:0]          rdata_o,
    input wire logic                ext_trigger_i,
    input wire logic                transmit_trigger_o,
    input wire logic [4:0]          profile_index_o,
    input wire logic                correction_enable_o,
    input wire logic                correction_clear_o
);
    import atpo_pkg::*;
    logic trg_w;
    logic man_w;
    logic cal_w;
    logic clr_w;
    logic trg_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // decoded writes of the trigger and calibration registers
    assign trg_w = req_i.wr && req_i.addr == ADDR_PROFILE_TRIG;
    assign man_w = trg_w && req_i.wdata[TRIG_BIT];
    assign cal_w = req_i.wr && req_i.addr == ADDR_OFFSET_CAL;
    assign clr_w = cal_w && req_i.wdata[2:0] == CAL_OFF;
    // marks the cycle the manual bit is set, so the pin path can be isolated
    always_ff @(posedge clk_i)
    begin
        trg_q <= resetn_i && man_w;
    end
    a_trig_pin: assert property (
        ext_trigger_i |=> transmit_trigger_o) else $error("pin trigger lost");
    a_trig_quiet: assert property (
        !ext_trigger_i && !trg_q |=> !transmit_trigger_o)
        else $error("spurious trigger");
    a_trig_manual: assert property (
        man_w |-> ##2 transmit_trigger_o) else $error("no manual trigger");
    a_trig_selfclear: assert property (
        trg_q && !man_w ##1 (req_i.addr == ADDR_PROFILE_TRIG && !trg_w)
        |=> !rdata_o[TRIG_BIT]) else $error("manual bit stuck");
    a_profile_load: assert property (
        trg_w ##1 !trg_w |-> ##1 profile_index_o == $past(req_i.wdata[4:0], 2))
        else $error("profile index wrong");
    a_clear_zero: assert property (
        clr_w |=> correction_clear_o) else $error("no correction clear");
    a_clear_cause: assert property (
        correction_clear_o |-> $past(clr_w)) else $error("stray clear");
    a_enable_code: assert property (
        cal_w && req_i.wdata[2:0] != CAL_OFF ##1 !cal_w
        |-> ##[0:1] correction_enable_o) else $error("correction off");
    a_status_restart: assert property (
        cal_w ##1 req_i.addr == ADDR_OFFSET_CAL |=> !rdata_o[CAL_DONE_BIT])
        else $error("status not cleared");
endmodule

bind atpo_ctrl atpo_ctrl_monitor i_mon (.clk_i, .resetn_i, .req_i, .rdata_o,
    .ext_trigger_i, .transmit_trigger_o, .profile_index_o,
    .correction_enable_o, .correction_clear_o);

//--- atpo_ctrl_bench.sv
// self-checking bench for the control register bank
`timescale 1ns/10ps
module atpo_ctrl_bench;
    import atpo_pkg::*;
    logic       clk_i = 0, resetn_i = 0, ext = 0, sv = 0;
    logic       g2, g3, act, trg, cen, ccl;
    logic [7:0] rdata_o, fp = 0, fn = 0;
    logic [4:0] prof;
    atpo_req_s  req = '0;
    int         failures = 0, tests_run = 0, n;
    logic [8:0] ra [8] = '{9'h106, 9'h108, 9'h109, 9'h10C, 9'h10D,
                           9'h10E, 9'h10F, 9'h100};
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF,
                           8'h00, 8'h00};
    always #5 clk_i = ~clk_i;
    atpo_ctrl i_dut (.clk_i, .resetn_i, .req_i(req), .rdata_o,
        .filter_out_p_i(fp), .filter_out_n_i(fn),
        .general_output_pin_two_o(g2), .general_output_pin_three_o(g3),
        .test_route_active_o(act), .ext_trigger_i(ext),
        .transmit_trigger_o(trg), .profile_index_o(prof),
        .sample_valid_i(sv), .correction_enable_o(cen),
        .correction_clear_o(ccl));
    // inputs always move 1 ns after the edge, outputs read there too
    task tick; @(posedge clk_i); #1; endtask
    task chk(input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e)
        begin
            failures++;
            $display("CHECK FAILED %0t got %h want %h", $time, s, e);
        end
    endtask
    task wr(input logic [8:0] a, input logic [7:0] d);
        req.addr = a; req.wdata = d; req.wr = 1; tick; req.wr = 0;
    endtask
    task rd(input logic [8:0] a, input logic [7:0] e);
        req.addr = a; tick; chk(rdata_o, e);
    endtask
    // reserved places hold their values and ignore writes
    task t_reset_map;
        for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
        wr(ADDR_RSVD_ONES_A, 8'h00); rd(ADDR_RSVD_ONES_A, 8'hFF);
        wr(ADDR_RSVD_ZERO_A, 8'hFF); rd(ADDR_RSVD_ZERO_A, 8'h00);
        chk(prof, 0);
    endtask
    // each channel in turn; upper junk bits must be masked
    task t_route;
        for (int s = 0; s < 8; s++)
        begin
            fp = 8'h01 << s; fn = ~fp;
            wr(ADDR_FILTER_TEST, 8'hE0 | 8'h10 | s[7:0]); tick; tick;
            chk({act, g2, g3}, 8'h06);
            rd(ADDR_FILTER_TEST, 8'h10 | s[7:0]);
        end
        fp = 8'hFF; wr(ADDR_FILTER_TEST, 8'h07); tick; tick; tick;
        chk({act, g2, g3}, 8'h00);
    endtask
    // pin path, then a manual shot that also loads the profile
    task t_trigger;
        ext = 1; tick; ext = 0; chk(trg, 1);
        tick; chk(trg, 0);
        wr(ADDR_PROFILE_TRIG, 8'h3F); tick; chk(trg, 1);
        rd(ADDR_PROFILE_TRIG, 8'h1F);
        chk(trg, 0);
        chk(prof, 8'h1F);
    endtask
    // shortest averaging run, then the off code clears correction
    task t_cal;
        wr(ADDR_OFFSET_CAL, 8'h01); sv = 1;
        rd(ADDR_OFFSET_CAL, 8'h01);
        for (n = 0; n < 1100 && rdata_o[CAL_DONE_BIT] !== 1'b1; n++) tick;
        // a hung calibration counts as a mismatch before the verdict
        if (n == 1100)
        begin
            failures++;
            test_done;
        end
        chk(8'(n > 1020 && n < 1030), 8'h01);
        chk(rdata_o, 8'h09);
        chk(cen, 1);
        wr(ADDR_OFFSET_CAL, 8'h00); chk(ccl, 1);
        tick; tick; chk({cen, ccl}, 8'h00);
        rd(ADDR_OFFSET_CAL, 8'h00);
        sv = 0;
    endtask
    task test_done;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (3) tick;
        resetn_i = 1;
        t_reset_map; t_route; t_trigger; t_cal;
        test_done;
    end
endmodule
